// file: sim/svi_i2c_port_checker.sv
// Purpose: pin-level assertions for the serial register port
// Assumes: control code stays at its reset value
// Notes:   bus state decoded from pin levels only
`timescale 1ns/1ns
`include "svi_consts.svh"
module svi_i2c_port_checker #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_sys_i,           // clock
  input wire logic reset_n_i,           // reset
  input wire logic scl_i,               // bus clock
  input wire logic sda_i,               // data wire
  input wire logic sda_o,               // data drive
  input wire logic sda_oe_n_o,          // drive enable
  input wire logic sense_ok_i,          // supply ok
  input wire logic manual_reset_in_n_i, // manual reset
  input wire logic reset_out_n_o        // reset out
);
  localparam logic [15:0] MINQ = 16'(16 * TICK_CYCLES);
  logic        scl_q, sda_q, first_q, wr_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  sh_q;
  logic [15:0] qc_q;
  wire         rise = scl_i & ~scl_q;
  wire         strt = scl_i & scl_q & sda_q & ~sda_i;
  wire         nine = rise && (bcnt_q == 4'h8);
  wire         quiet = sense_ok_i & manual_reset_in_n_i & reset_n_i;
  always_ff @(posedge clk_sys_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    qc_q  <= quiet ? qc_q + {15'h0000, qc_q != 16'hFFFF} : 16'h0000;
    if (strt || !reset_n_i) begin
      bcnt_q  <= 4'h0;
      first_q <= 1'h1;
      wr_q    <= 1'h0;
    end else if (rise) begin
      bcnt_q  <= nine ? 4'h0 : bcnt_q + 4'h1;
      sh_q    <= nine ? sh_q : {sh_q[6:0], sda_i};
      first_q <= nine ? 1'h0 : first_q;
      wr_q    <= (nine && first_q) ? (sh_q[7:4] == `SVI_RST_CODE) && !sh_q[0] : wr_q;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  property p_rst; $rose(reset_n_i) |-> sda_oe_n_o && !reset_out_n_o; endproperty
  property p_sense; (!sense_ok_i) [*5] |-> !reset_out_n_o; endproperty
  property p_mr; (!manual_reset_in_n_i) [*5] |-> !reset_out_n_o; endproperty
  property p_rel; $rose(reset_out_n_o) |-> qc_q > MINQ; endproperty
  property p_stand; scl_i |-> $stable(sda_oe_n_o); endproperty
  property p_ack; nine && first_q && sh_q[7:4] == `SVI_RST_CODE |-> !sda_oe_n_o; endproperty
  property p_nack; nine && first_q && sh_q[7:4] != `SVI_RST_CODE |-> sda_oe_n_o; endproperty
  property p_dack; nine && !first_q && wr_q |-> !sda_oe_n_o; endproperty
  property p_od; !sda_oe_n_o |-> !sda_o; endproperty
  a_rst: assert property (p_rst) else $error("bad outputs after reset");
  a_sense: assert property (p_sense) else $error("no reset on low supply");
  a_mr: assert property (p_mr) else $error("no reset on manual reset");
  a_rel: assert property (p_rel) else $error("reset released early");
  a_stand: assert property (p_stand) else $error("data moved in clock high");
  a_ack: assert property (p_ack) else $error("control byte not acked");
  a_nack: assert property (p_nack) else $error("foreign code acked");
  a_dack: assert property (p_dack) else $error("write byte not acked");
  a_od: assert property (p_od) else $error("data line driven high");
  c_rd: cover property (nine && first_q && sh_q[0] && !sda_oe_n_o);
  c_wr: cover property (nine && !first_q && wr_q);
  c_rel: cover property ($rose(reset_out_n_o));
endmodule
bind svi_i2c_port svi_i2c_port_checker #(.TICK_CYCLES(TICK_CYCLES)) i_svi_i2c_port_checker (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o),
  .sense_ok_i(sense_ok_i),
  .manual_reset_in_n_i(manual_reset_in_n_i),
  .reset_out_n_o(reset_out_n_o)
);

// file: sim/svi_i2c_port_tb.sv
// Purpose: self-checking bench for the serial register port
// Assumes: timer tick shortened to 10 clocks
// Notes:   data wire resolved here with a pull-up
`timescale 1ns/1ns
`include "svi_consts.svh"
module svi_i2c_port_tb;
  logic       clk_sys_i, reset_n_i, scl, m_sda, sda_o, sda_oe_n;
  logic       sense_ok, mr_n, rst_out_n, ak;
  logic [7:0] q;
  int         fails = 0;
  int         num_checks = 0;
  int         cyc = 0;
  wire        sda_w = m_sda & (sda_oe_n | sda_o);
  svi_i2c_port #(.TICK_CYCLES(10)) i_svi_i2c_port (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n),
    .sense_ok_i(sense_ok),
    .manual_reset_in_n_i(mr_n),
    .reset_out_n_o(rst_out_n)
  );
  svi_master i_svi_master (
    .clk_i(clk_sys_i),
    .sda_i(sda_w),
    .scl_o(scl),
    .sda_o(m_sda)
  );
  initial begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ctl(input logic [10:0] a);
    i_svi_master.bus_start();
    i_svi_master.xfer({`SVI_RST_CODE, a[10:8], 1'h0}, 1'h1, q, ak);
    chk({7'h00, ak}, 8'h00);
    i_svi_master.xfer(a[7:0], 1'h1, q, ak);
    chk({7'h00, ak}, 8'h00);
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d, input int n);
    ctl(a);
    for (int i = 0; i < n; i++) begin
      i_svi_master.xfer(d[8*i +: 8], 1'h1, q, ak);
      chk({7'h00, ak}, 8'h00);
    end
    i_svi_master.bus_stop();
  endtask
  task automatic rd(input logic [10:0] a, input logic [15:0] e, input int n);
    ctl(a);
    i_svi_master.bus_start();
    i_svi_master.xfer({`SVI_RST_CODE, a[10:8], 1'h1}, 1'h1, q, ak);
    chk({7'h00, ak}, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_svi_master.xfer(8'hFF, i == n - 1, q, ak);
      chk(q, e[8*i +: 8]);
    end
    i_svi_master.bus_stop();
  endtask
  task automatic hold(input logic which, input int t);
    mr_n = ~which;
    sense_ok = which;
    repeat (20) @(negedge clk_sys_i);
    chk({7'h00, rst_out_n}, 8'h00);
    mr_n = 1'h1;
    sense_ok = 1'h1;
    repeat (t - 40) @(negedge clk_sys_i);
    chk({7'h00, rst_out_n}, 8'h00);
    repeat (80) @(negedge clk_sys_i);
    chk({7'h00, rst_out_n}, 8'h01);
  endtask
  initial begin
    reset_n_i = 1'h0;
    sense_ok = 1'h1;
    mr_n = 1'h1;
    repeat (5) @(negedge clk_sys_i);
    reset_n_i = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    rd(`SVI_ADDR_DLYA_LO, {`SVI_RST_DLYA_HI, `SVI_RST_DLYA_LO}, 2);
    $display("test reset values done");
    wr(`SVI_ADDR_DLYA_LO, 16'h0107, 2);
    wr(`SVI_ADDR_DLYB, 16'h0040, 1);
    wr(11'h195, 16'h00AA, 1);
    rd(`SVI_ADDR_DLYA_LO, 16'h0107, 2);
    $display("test writes done");
    ctl(`SVI_ADDR_DLYB);
    i_svi_master.xfer(8'h55, 1'h1, q, ak);
    chk({7'h00, ak}, 8'h00);
    rd(`SVI_ADDR_DLYB, 16'h0055, 1);
    rd(`SVI_ADDR_CODE, {8'h00, 4'h0, `SVI_RST_CODE}, 1);
    i_svi_master.bus_start();
    i_svi_master.xfer(8'h20, 1'h1, q, ak);
    chk({7'h00, ak}, 8'h01);
    i_svi_master.bus_stop();
    $display("test commit and refusal done");
    hold(1'h1, 2630);
    hold(1'h0, 2630);
    $display("test reset timers done");
    report_and_stop();
  end
endmodule

// file: sim/svi_master.sv
// Purpose: bus master model for the serial register port
// Assumes: wire resolved by the bench with a pull-up
// Notes:   pins change on falling clock edges only
`timescale 1ns/1ns
module svi_master (
  input  wire logic clk_i,  // system clock
  input  wire logic sda_i,  // resolved data wire
  output logic      scl_o,  // bus clock
  output logic      sda_o   // data drive, 1 releases
);
  localparam int LO = 65;
  localparam int HI = 60;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic bus_start();
    sda_o = 1'h1;
    wait_n(2 * LO);
    scl_o = 1'h1;
    wait_n(2 * HI);
    sda_o = 1'h0;
    wait_n(2 * HI);
    scl_o = 1'h0;
    wait_n(LO);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    wait_n(LO);
    scl_o = 1'h1;
    wait_n(HI);
    r = sda_i;
    wait_n(HI);
    scl_o = 1'h0;
    wait_n(LO);
  endtask
  // last is the ninth bit: 1 releases for the target, 0 acks read data
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(last, a);
  endtask
  task automatic bus_stop();
    sda_o = 1'h0;
    wait_n(LO);
    scl_o = 1'h1;
    wait_n(2 * HI);
    sda_o = 1'h1;
    wait_n(2 * LO);
  endtask
endmodule

// file: src/svi_consts.svh
// Purpose: named constants of the supervisor serial register port
// Assumes: 100 MHz system clock
// Notes:   addresses are 11-bit byte locations, block bits on top
`ifndef SVI_CONSTS_SVH
`define SVI_CONSTS_SVH

`define SVI_CLK_NS         10
`define SVI_TICK_NS        100000
`define SVI_HOLD_MS        20
`define SVI_HOLD_TICKS     ((`SVI_HOLD_MS * 1000000) / `SVI_TICK_NS)

`define SVI_ADDR_DLYA_LO   11'h095
`define SVI_ADDR_DLYA_HI   11'h096
`define SVI_ADDR_DLYB      11'h098
`define SVI_ADDR_CODE      11'h0FD

`define SVI_RST_DLYA_LO    8'hC8
`define SVI_RST_DLYA_HI    8'h00
`define SVI_RST_DLYB       8'hC8
`define SVI_RST_CODE       4'h1

`define SVI_BITS_PER_BYTE  4'h8
`define SVI_CODE_HI        7
`define SVI_CODE_LO        4
`define SVI_BLK_HI         3
`define SVI_BLK_LO         1
`define SVI_RW_BIT         0
`define SVI_PTR_BLK_HI     10
`define SVI_PTR_BLK_LO     8

`endif

// file: src/svi_delay_timer.sv
// Purpose: hold timer that expires on the tick after the programmed count of ticks since release
// Assumes: tick_i is a one-cycle enable from a divider
// Notes:   restarts whenever hold_i is high
`timescale 1ns/1ns
`include "svi_consts.svh"
module svi_delay_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_sys_i,  // system clock
  input  wire logic         reset_n_i,  // synchronous reset, active low
  input  wire logic         hold_i,     // reset condition present
  input  wire logic         tick_i,     // timebase enable
  input  wire logic [W-1:0] count_i,    // programmed interval in ticks
  output logic              done_o      // interval elapsed since release
);
  import svi_pkg::*;

  svi_timer_t q;
  svi_timer_t d;

  always_comb begin
    d = q;
    if (hold_i) begin
      d.cnt  = '0;
      d.done = 1'b0;
    end else if (tick_i && !q.done) begin
      if (q.cnt[W-1:0] >= count_i) begin
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;
endmodule

// file: src/svi_i2c_port.sv
// Purpose: serial target port for the delay-timer registers of a supervisor
// Assumes: bus clock well below the 100 MHz system clock; pins are asynchronous
// Notes:   only the mapped locations hold data; others read zero, writes dropped
//
// How it works
// - answer only when control code matches
// - three block bits follow the code
// - last control bit: 0 write, 1 read
// - acknowledge matching control byte on ninth clock
// - pointer is block bits above word address
// - byte write: ack address, ack data
// - data committed when its ack is driven
// - repeated start drops write, keeps pointer
// - read control acked, eight bits shifted out
// - timer A count read as two bytes
// - timer B count read as one byte
// - reset held until both timer A and timer B intervals elapse after release
`timescale 1ns/1ns
`include "svi_consts.svh"
module svi_i2c_port #(
  parameter int TICK_CYCLES = `SVI_TICK_NS / `SVI_CLK_NS
) (
  input  wire logic clk_sys_i,            // system clock
  input  wire logic reset_n_i,            // synchronous reset, active low
  input  wire logic scl_i,                // serial clock pin
  input  wire logic sda_i,                // serial data pin level
  output logic      sda_o,                // serial data drive level
  output logic      sda_oe_n_o,           // low while driving the data line
  input  wire logic sense_ok_i,           // comparator: supply above threshold
  input  wire logic manual_reset_in_n_i,  // manual reset pin, active low
  output logic      reset_out_n_o         // supervisor reset output, active low
);
  import svi_pkg::*;

  localparam svi_port_t RESET_VAL = '{
    st:         SVI_IDLE,
    bitcnt:     4'h0,
    shreg:      8'h00,
    ptr:        11'h000,
    rw:         1'b0,
    nack:       1'b1,
    sda_oe_n:   1'b1,
    sda_lvl:    1'b0,
    scl_sync:   3'h7,
    sda_sync:   3'h7,
    sense_sync: 2'h0,
    mr_sync:    2'h0,
    dly_a_lo:   `SVI_RST_DLYA_LO,
    dly_a_hi:   `SVI_RST_DLYA_HI,
    dly_b:      `SVI_RST_DLYB,
    code:       `SVI_RST_CODE,
    tick_cnt:   16'h0000,
    tick:       1'b0,
    rst_out_n:  1'b0
  };

  svi_port_t q;
  svi_port_t d;
  logic      done_a;
  logic      done_b;
  logic      hold;

  function automatic logic [7:0] rd_mux(input svi_port_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (s.ptr)
      `SVI_ADDR_DLYA_LO: v = s.dly_a_lo;
      `SVI_ADDR_DLYA_HI: v = s.dly_a_hi;
      `SVI_ADDR_DLYB:    v = s.dly_b;
      `SVI_ADDR_CODE:    v = {4'h0, s.code};
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_byte;

  always_comb begin
    scl_s    = q.scl_sync[1];
    scl_p    = q.scl_sync[2];
    sda_s    = q.sda_sync[1];
    sda_p    = q.sda_sync[2];
    scl_rise = scl_s && !scl_p;
    scl_fall = !scl_s && scl_p;
    start_c  = scl_s && scl_p && sda_p && !sda_s;
    stop_c   = scl_s && scl_p && !sda_p && sda_s;
    rd_byte  = rd_mux(q);
    hold     = !q.sense_sync[1] || !q.mr_sync[1];
  end

  always_comb begin
    d = q;
    d.scl_sync   = {q.scl_sync[1:0], scl_i};
    d.sda_sync   = {q.sda_sync[1:0], sda_i};
    d.sense_sync = {q.sense_sync[0], sense_ok_i};
    d.mr_sync    = {q.mr_sync[0], manual_reset_in_n_i};

    // timebase for the hold timers
    d.tick = 1'b0;
    if (q.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
      d.tick_cnt = 16'h0000;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 16'h0001;
    end
    d.rst_out_n = done_a && done_b && !hold;

    if (start_c) begin
      // a repeated start abandons any write; the pointer stays
      d.st       = SVI_CTRL;
      d.bitcnt   = 4'h0;
      d.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      d.st       = SVI_IDLE;
      d.sda_oe_n = 1'b1;
    end else begin
      unique case (q.st)
        SVI_IDLE: begin
          d.sda_oe_n = 1'b1;
        end
        SVI_CTRL, SVI_WADDR, SVI_WDATA: begin
          if (scl_rise) begin
            d.shreg  = {q.shreg[6:0], sda_s};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == `SVI_BITS_PER_BYTE) begin
            d.bitcnt = 4'h0;
            if (q.st == SVI_CTRL) begin
              if (q.shreg[`SVI_CODE_HI:`SVI_CODE_LO] == q.code) begin
                d.rw       = q.shreg[`SVI_RW_BIT];
                d.ptr[`SVI_PTR_BLK_HI:`SVI_PTR_BLK_LO] =
                  q.shreg[`SVI_BLK_HI:`SVI_BLK_LO];
                d.sda_oe_n = 1'b0;
                d.st       = SVI_CTRL_ACK;
              end else begin
                d.sda_oe_n = 1'b1;
                d.st       = SVI_IDLE;
              end
            end else if (q.st == SVI_WADDR) begin
              d.ptr[7:0] = q.shreg;
              d.sda_oe_n = 1'b0;
              d.st       = SVI_WADDR_ACK;
            end else begin
              unique case (q.ptr)
                `SVI_ADDR_DLYA_LO: d.dly_a_lo = q.shreg;
                `SVI_ADDR_DLYA_HI: d.dly_a_hi = q.shreg;
                `SVI_ADDR_DLYB:    d.dly_b    = q.shreg;
                `SVI_ADDR_CODE:    d.code     = q.shreg[3:0];
                default:           d.code     = q.code;
              endcase
              d.ptr      = q.ptr + 11'h001;
              d.sda_oe_n = 1'b0;
              d.st       = SVI_WDATA_ACK;
            end
          end
        end
        SVI_CTRL_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.shreg    = {rd_byte[6:0], 1'b0};
              d.sda_oe_n = rd_byte[7];
              d.bitcnt   = 4'h1;
              d.ptr      = q.ptr + 11'h001;
              d.st       = SVI_RDATA;
            end else begin
              d.sda_oe_n = 1'b1;
              d.st       = SVI_WADDR;
            end
          end
        end
        SVI_WADDR_ACK, SVI_WDATA_ACK: begin
          if (scl_fall) begin
            d.sda_oe_n = 1'b1;
            d.st       = SVI_WDATA;
          end
        end
        SVI_RDATA: begin
          if (scl_fall) begin
            if (q.bitcnt == `SVI_BITS_PER_BYTE) begin
              d.sda_oe_n = 1'b1;
              d.bitcnt   = 4'h0;
              d.st       = SVI_RACK;
            end else begin
              d.sda_oe_n = q.shreg[7];
              d.shreg    = {q.shreg[6:0], 1'b0};
              d.bitcnt   = q.bitcnt + 4'h1;
            end
          end
        end
        SVI_RACK: begin
          if (scl_rise) begin
            d.nack = sda_s;
          end else if (scl_fall) begin
            if (!q.nack) begin
              d.shreg    = {rd_byte[6:0], 1'b0};
              d.sda_oe_n = rd_byte[7];
              d.bitcnt   = 4'h1;
              d.ptr      = q.ptr + 11'h001;
              d.st       = SVI_RDATA;
            end else begin
              d.st       = SVI_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  svi_delay_timer #(
    .W (16)
  ) u_delay_timer_a (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .hold_i    (hold),
    .tick_i    (q.tick),
    .count_i   ({q.dly_a_hi, q.dly_a_lo}),
    .done_o    (done_a)
  );

  svi_delay_timer #(
    .W (8)
  ) u_delay_timer_b (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .hold_i    (hold),
    .tick_i    (q.tick),
    .count_i   (q.dly_b),
    .done_o    (done_b)
  );

  assign sda_o         = q.sda_lvl;
  assign sda_oe_n_o    = q.sda_oe_n;
  assign reset_out_n_o = q.rst_out_n;
endmodule

// file: src/svi_pkg.sv
// Purpose: types of the supervisor serial register port
// Assumes: none
// Notes:   states are one-hot
package svi_pkg;

  typedef enum logic [8:0] {
    SVI_IDLE      = 9'h001,
    SVI_CTRL      = 9'h002,
    SVI_CTRL_ACK  = 9'h004,
    SVI_WADDR     = 9'h008,
    SVI_WADDR_ACK = 9'h010,
    SVI_WDATA     = 9'h020,
    SVI_WDATA_ACK = 9'h040,
    SVI_RDATA     = 9'h080,
    SVI_RACK      = 9'h100
  } svi_state_t;

  typedef struct packed {
    svi_state_t  st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [10:0] ptr;
    logic        rw;
    logic        nack;
    logic        sda_oe_n;
    logic        sda_lvl;
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    logic [1:0]  sense_sync;
    logic [1:0]  mr_sync;
    logic [7:0]  dly_a_lo;
    logic [7:0]  dly_a_hi;
    logic [7:0]  dly_b;
    logic [3:0]  code;
    logic [15:0] tick_cnt;
    logic        tick;
    logic        rst_out_n;
  } svi_port_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
  } svi_timer_t;

endpackage
